/* rtl/cic_core.sv */
// Core interrupt control: control register, flags, request to the core, event interrupt.
//
// Overview of operation
// - Bit 7 is the global enable; at 0 no request ever reaches the core.
// - Bit 6 is the peripheral-group enable; at 0 all peripheral requests are masked.
// - Bit 5 enables the timer overflow interrupt.
// - Bit 4 enables the external pin interrupt.
// - Bit 3 enables the pin-change interrupt.
// - Bit 2 is set on a timer count overflow or by a software write of 1, and holds until software writes 0.
// - Bit 1 is set on an external pin event or by a software write of 1, and holds until software writes 0.
// - Bit 0 reads 1 while any monitored pin has a pending change flag.
// - Bit 0 ignores writes and clears only when every per-pin flag is cleared.
// - Flags are set by their sources regardless of any enable bit.
// - Every bit of the control register resets to 0.
// - Bits 7 to 1 are read and write, bit 0 is read only.
// - A peripheral request reaches the core only with the group enable set.
`timescale 1ns/1ps
module cic_core
    import cic_pkg::*;
#(
    parameter int unsigned PINS = CIC_PINS_DEF
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // Register port
    input wire logic [CIC_ADDR_W-1:0] i_addr,
    input wire logic [CIC_DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [CIC_DATA_W-1:0] o_rdata,
    // Interrupt sources
    input wire logic i_timer_overflow,
    input wire logic i_ext_pin_event,
    input wire logic i_periph_pending,
    input wire logic [PINS-1:0] i_pins,
    // Requests
    output logic o_core_irq,
    output logic o_irq
);

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic hit(input logic [CIC_ADDR_W-1:0] a,
                                 input logic [CIC_ADDR_W-1:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    ////////////////////////////////////////////////////////////////////////////////
    // Bus and source carriers

    cic_bus_req_t req;
    cic_src_t src;

    assign req.addr = i_addr;
    assign req.wdata = i_wdata;
    assign req.wr = i_wr;
    assign req.rd = i_rd;

    assign src.timer_overflow = i_timer_overflow;
    assign src.ext_pin = i_ext_pin_event;
    assign src.periph_pending = i_periph_pending;

    ////////////////////////////////////////////////////////////////////////////////
    // Address decode

    wire logic wr_ctrl;
    wire logic wr_pins;
    wire logic wr_evt_clr;
    wire logic wr_evt_en;

    assign wr_ctrl = req.wr && hit(req.addr, CIC_OFS_INTERRUPT_CONTROL);
    assign wr_pins = req.wr && hit(req.addr, CIC_OFS_PER_PIN_FLAGS);
    assign wr_evt_clr = req.wr && hit(req.addr, CIC_OFS_EVT_CLEAR);
    assign wr_evt_en = req.wr && hit(req.addr, CIC_OFS_EVT_ENABLE);

    ////////////////////////////////////////////////////////////////////////////////
    // Per-pin change flags

    logic [PINS-1:0] pin_flags;
    logic pin_new_change;

    cic_pin_change #(
        .PINS(PINS)
    ) u_pin_change (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_pins(i_pins),
        .i_flag_we(wr_pins),
        .i_flag_wdata(req.wdata[PINS-1:0]),
        .o_flags(pin_flags),
        .o_new_change(pin_new_change)
    );

    // Summary is pure hardware state; writes can only clear it through the per-pin flags
    wire logic pchg_summary;
    assign pchg_summary = |pin_flags;

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupt control register

    logic global_irq_enable_q;
    logic peripheral_group_enable_q;
    logic timer_overflow_irq_enable_q;
    logic ext_pin_irq_enable_q;
    logic pin_change_irq_enable_q;
    logic timer_overflow_flag_q;
    logic timer_overflow_flag_d;
    logic ext_pin_flag_q;
    logic ext_pin_flag_d;

    // Set wins over a software write of 0 in the same cycle
    assign timer_overflow_flag_d = src.timer_overflow
        | (wr_ctrl ? req.wdata[CIC_BIT_TMR_FLAG] : timer_overflow_flag_q);
    assign ext_pin_flag_d = src.ext_pin
        | (wr_ctrl ? req.wdata[CIC_BIT_EXT_FLAG] : ext_pin_flag_q);

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            global_irq_enable_q <= CIC_RST_INTERRUPT_CONTROL[CIC_BIT_GLOBAL_EN];
            peripheral_group_enable_q <= CIC_RST_INTERRUPT_CONTROL[CIC_BIT_PERIPH_EN];
            timer_overflow_irq_enable_q <= CIC_RST_INTERRUPT_CONTROL[CIC_BIT_TMR_EN];
            ext_pin_irq_enable_q <= CIC_RST_INTERRUPT_CONTROL[CIC_BIT_EXT_EN];
            pin_change_irq_enable_q <= CIC_RST_INTERRUPT_CONTROL[CIC_BIT_PCHG_EN];
            timer_overflow_flag_q <= CIC_RST_INTERRUPT_CONTROL[CIC_BIT_TMR_FLAG];
            ext_pin_flag_q <= CIC_RST_INTERRUPT_CONTROL[CIC_BIT_EXT_FLAG];
        end else begin
            if (wr_ctrl) begin
                global_irq_enable_q <= req.wdata[CIC_BIT_GLOBAL_EN];
                peripheral_group_enable_q <= req.wdata[CIC_BIT_PERIPH_EN];
                timer_overflow_irq_enable_q <= req.wdata[CIC_BIT_TMR_EN];
                ext_pin_irq_enable_q <= req.wdata[CIC_BIT_EXT_EN];
                pin_change_irq_enable_q <= req.wdata[CIC_BIT_PCHG_EN];
            end
            timer_overflow_flag_q <= timer_overflow_flag_d;
            ext_pin_flag_q <= ext_pin_flag_d;
        end
    end

    wire logic [CIC_DATA_W-1:0] ctrl_value;
    assign ctrl_value = {global_irq_enable_q, peripheral_group_enable_q,
                         timer_overflow_irq_enable_q, ext_pin_irq_enable_q,
                         pin_change_irq_enable_q, timer_overflow_flag_q,
                         ext_pin_flag_q, pchg_summary};

    ////////////////////////////////////////////////////////////////////////////////
    // Request to the core
    // A stale flag fires as soon as its enable is set; software clears it first.

    wire logic tmr_req;
    wire logic ext_req;
    wire logic pchg_req;
    wire logic periph_req;
    wire logic core_req;

    assign tmr_req = timer_overflow_flag_q & timer_overflow_irq_enable_q;
    assign ext_req = ext_pin_flag_q & ext_pin_irq_enable_q;
    assign pchg_req = pchg_summary & pin_change_irq_enable_q;
    assign periph_req = src.periph_pending & peripheral_group_enable_q;
    assign core_req = global_irq_enable_q
        & (tmr_req | ext_req | pchg_req | periph_req);

    logic core_irq_q;

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            core_irq_q <= 1'b0;
        end else begin
            core_irq_q <= core_req;
        end
    end

    assign o_core_irq = core_irq_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Event status, clear and enable

    logic [CIC_EVT_W-1:0] evt_status_q;
    logic [CIC_EVT_W-1:0] evt_enable_q;
    logic irq_q;
    wire logic [CIC_EVT_W-1:0] evt_set;
    wire logic [CIC_EVT_W-1:0] evt_clr;
    wire logic [CIC_EVT_W-1:0] evt_status_d;

    assign evt_set[CIC_EVT_TMR] = src.timer_overflow;
    assign evt_set[CIC_EVT_EXT] = src.ext_pin;
    assign evt_set[CIC_EVT_PCHG] = pin_new_change;
    assign evt_clr = wr_evt_clr ? req.wdata[CIC_EVT_W-1:0] : '0;
    // Set beats clear so an event in the clearing cycle survives
    assign evt_status_d = (evt_status_q & ~evt_clr) | evt_set;

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            evt_status_q <= CIC_RST_EVT;
            evt_enable_q <= CIC_RST_EVT;
            irq_q <= 1'b0;
        end else begin
            evt_status_q <= evt_status_d;
            if (wr_evt_en) begin
                evt_enable_q <= req.wdata[CIC_EVT_W-1:0];
            end
            irq_q <= |(evt_status_d & (wr_evt_en ? req.wdata[CIC_EVT_W-1:0] : evt_enable_q));
        end
    end

    assign o_irq = irq_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Read path; clear register is write only and reads as zero

    logic [CIC_DATA_W-1:0] rdata_q;
    logic [CIC_DATA_W-1:0] rd_mux;

    always_comb begin
        rd_mux = CIC_RD_UNMAPPED;
        case (req.addr)
            CIC_OFS_INTERRUPT_CONTROL: rd_mux = ctrl_value;
            CIC_OFS_PER_PIN_FLAGS: rd_mux = CIC_DATA_W'(pin_flags);
            CIC_OFS_EVT_STATUS: rd_mux = CIC_DATA_W'(evt_status_q);
            CIC_OFS_EVT_ENABLE: rd_mux = CIC_DATA_W'(evt_enable_q);
            default: rd_mux = CIC_RD_UNMAPPED;
        endcase
    end

    // Data stands only in the cycle after the read strobe
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            rdata_q <= CIC_RD_UNMAPPED;
        end else if (req.rd) begin
            rdata_q <= rd_mux;
        end else begin
            rdata_q <= CIC_RD_UNMAPPED;
        end
    end

    assign o_rdata = rdata_q;

endmodule : cic_core

/* rtl/cic_pkg.sv */
// Package for the core interrupt control block: offsets, bit positions, reset values, carriers.
package cic_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Widths
    localparam int unsigned CIC_ADDR_W = 3;
    localparam int unsigned CIC_DATA_W = 8;
    localparam int unsigned CIC_PINS_DEF = 6;

    ////////////////////////////////////////////////////////////////////////////////
    // Register offsets
    localparam logic [CIC_ADDR_W-1:0] CIC_OFS_INTERRUPT_CONTROL = 3'h0;
    localparam logic [CIC_ADDR_W-1:0] CIC_OFS_PER_PIN_FLAGS = 3'h1;
    localparam logic [CIC_ADDR_W-1:0] CIC_OFS_EVT_STATUS = 3'h2;
    localparam logic [CIC_ADDR_W-1:0] CIC_OFS_EVT_CLEAR = 3'h3;
    localparam logic [CIC_ADDR_W-1:0] CIC_OFS_EVT_ENABLE = 3'h4;

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupt control bit positions
    localparam int unsigned CIC_BIT_GLOBAL_EN = 7;
    localparam int unsigned CIC_BIT_PERIPH_EN = 6;
    localparam int unsigned CIC_BIT_TMR_EN = 5;
    localparam int unsigned CIC_BIT_EXT_EN = 4;
    localparam int unsigned CIC_BIT_PCHG_EN = 3;
    localparam int unsigned CIC_BIT_TMR_FLAG = 2;
    localparam int unsigned CIC_BIT_EXT_FLAG = 1;
    localparam int unsigned CIC_BIT_PCHG_FLAG = 0;

    ////////////////////////////////////////////////////////////////////////////////
    // Event status bit positions
    localparam int unsigned CIC_EVT_W = 3;
    localparam int unsigned CIC_EVT_TMR = 0;
    localparam int unsigned CIC_EVT_EXT = 1;
    localparam int unsigned CIC_EVT_PCHG = 2;

    ////////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [CIC_DATA_W-1:0] CIC_RST_INTERRUPT_CONTROL = 8'h00;
    localparam logic [CIC_EVT_W-1:0] CIC_RST_EVT = 3'h0;
    localparam logic [CIC_DATA_W-1:0] CIC_RD_UNMAPPED = 8'h00;

    ////////////////////////////////////////////////////////////////////////////////
    // Register bus request carrier
    typedef struct packed {
        logic [CIC_ADDR_W-1:0] addr;
        logic [CIC_DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } cic_bus_req_t;

    // Source event carrier
    typedef struct packed {
        logic timer_overflow;
        logic ext_pin;
        logic periph_pending;
    } cic_src_t;

endpackage : cic_pkg

/* rtl/cic_pin_change.sv */
// Per-pin change detector with software-cleared per-pin change flags.
`timescale 1ns/1ps
module cic_pin_change
    import cic_pkg::*;
#(
    parameter int unsigned PINS = CIC_PINS_DEF
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // Monitored pins
    input wire logic [PINS-1:0] i_pins,
    // Software access to the per-pin flags
    input wire logic i_flag_we,
    input wire logic [PINS-1:0] i_flag_wdata,
    // Flags and new-change pulse
    output logic [PINS-1:0] o_flags,
    output logic o_new_change
);

    logic [PINS-1:0] prev_q;
    logic primed_q;
    logic [PINS-1:0] flags_q;
    logic [PINS-1:0] flags_d;
    logic new_change_q;
    wire logic [PINS-1:0] changed;

    ////////////////////////////////////////////////////////////////////////////////
    // Change detection; first sample after reset only primes, no false change
    assign changed = primed_q ? (prev_q ^ i_pins) : '0;

    // Writing 0 clears a flag; a change in the same cycle still sets it
    assign flags_d = (i_flag_we ? (flags_q & i_flag_wdata) : flags_q) | changed;

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            prev_q <= '0;
            primed_q <= 1'b0;
            flags_q <= '0;
            new_change_q <= 1'b0;
        end else begin
            prev_q <= i_pins;
            primed_q <= 1'b1;
            flags_q <= flags_d;
            new_change_q <= |changed;
        end
    end

    assign o_flags = flags_q;
    assign o_new_change = new_change_q;

endmodule : cic_pin_change

/* verif/cic_monitor.sv */
// Port checker for the core interrupt control block.
`timescale 1ns/1ps
module cic_monitor
    import cic_pkg::*;
#(
    parameter int unsigned PINS = CIC_PINS_DEF
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // Register port
    input wire logic [CIC_ADDR_W-1:0] i_addr,
    input wire logic [CIC_DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [CIC_DATA_W-1:0] o_rdata,
    // Sources and requests
    input wire logic i_timer_overflow,
    input wire logic i_ext_pin_event,
    input wire logic i_periph_pending,
    input wire logic [PINS-1:0] i_pins,
    input wire logic o_core_irq,
    input wire logic o_irq
);
    logic [7:3] en_q;
    logic [2:0] evt_en_q;
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    //////////////////////////////////////////////////////////////////////
    // Shadow of enables; flags are left out since sources set them too
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            en_q <= 5'h00;
            evt_en_q <= 3'h0;
        end else if (i_wr && i_addr == CIC_OFS_INTERRUPT_CONTROL) begin
            en_q <= i_wdata[7:3];
        end else if (i_wr && i_addr == CIC_OFS_EVT_ENABLE) begin
            evt_en_q <= i_wdata[2:0];
        end
    end
    sequence tmr_seen_s;
        i_timer_overflow ##1 (en_q[7] && en_q[5]);
    endsequence
    sequence pchg_seen_s;
        $changed(i_pins) ##1 (en_q[7] && en_q[3]);
    endsequence
    //////////////////////////////////////////////////////////////////////
    ctrl_rback_a: assert property (
        $past(i_rd) && $past(i_addr) == 3'h0 |-> o_rdata[7:3] == $past(en_q))
        else $error("control read back differs");
    rd_unmap_a: assert property ($past(i_rd) && $past(i_addr) > 3'h4 |-> o_rdata == 8'h00)
        else $error("unmapped read not zero");
    glob_off_a: assert property (!$past(en_q[7]) |-> !o_core_irq)
        else $error("request with global enable off");
    all_masked_a: assert property (
        !$past(en_q[6]) && $past(en_q[5:3]) == 3'h0 |-> !o_core_irq)
        else $error("request with every source masked");
    tmr_req_a: assert property (tmr_seen_s |=> o_core_irq)
        else $error("timer request missing");
    pchg_req_a: assert property (pchg_seen_s |=> o_core_irq)
        else $error("pin change request missing");
    periph_req_a: assert property (
        i_periph_pending && en_q[7] && en_q[6] |=> o_core_irq)
        else $error("peripheral request missing");
    evt_irq_a: assert property (i_timer_overflow && evt_en_q[0] && !i_wr |=> o_irq)
        else $error("event interrupt missing");
endmodule : cic_monitor

bind cic_core cic_monitor #(.PINS(PINS)) u_mon (
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_timer_overflow(i_timer_overflow),
    .i_ext_pin_event(i_ext_pin_event), .i_periph_pending(i_periph_pending),
    .i_pins(i_pins), .o_core_irq(o_core_irq), .o_irq(o_irq));

/* verif/cic_src_model.sv */
// Model of the timer, external pin, peripheral and pin sources.
`timescale 1ns/1ps
module cic_src_model
    import cic_pkg::*;
#(
    parameter int unsigned PINS = CIC_PINS_DEF
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // Requests from the bench; timer, external pin and flip one cycle each, pending held as a level
    input wire logic i_tmr_req,
    input wire logic i_ext_req,
    input wire logic i_pend_req,
    input wire logic [PINS-1:0] i_flip_req,
    // Sources
    output cic_src_t o_src,
    output logic [PINS-1:0] o_pins
);
    // Registered so every source change lands just after a clock edge
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_src <= '0;
            o_pins <= '0;
        end else begin
            o_src.timer_overflow <= i_tmr_req;
            o_src.ext_pin <= i_ext_req;
            o_src.periph_pending <= i_pend_req;
            o_pins <= o_pins ^ i_flip_req;
        end
    end
endmodule : cic_src_model

/* verif/cic_core_tb_top.sv */
// Self-checking bench for the core interrupt control block.
`timescale 1ns/1ps
module cic_core_tb_top
    import cic_pkg::*;
;
    logic i_clk_sys, i_rst_n, i_wr, i_rd;
    logic [2:0] i_addr;
    logic [7:0] i_wdata;
    wire [7:0] o_rdata;
    wire o_core_irq, o_irq;
    cic_src_t src_w;
    logic tmr_req, ext_req, pend_req;
    logic [5:0] flip_req;
    wire [5:0] pins_w;
    int n_errors = 0;
    int num_checks = 0;
    int cyc = 0;
    cic_core #(.PINS(6)) dut (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_timer_overflow(src_w.timer_overflow), .i_ext_pin_event(src_w.ext_pin),
        .i_periph_pending(src_w.periph_pending), .i_pins(pins_w),
        .o_core_irq(o_core_irq), .o_irq(o_irq));
    cic_src_model #(.PINS(6)) src (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
        .i_tmr_req(tmr_req), .i_ext_req(ext_req), .i_pend_req(pend_req),
        .i_flip_req(flip_req), .o_src(src_w), .o_pins(pins_w));
    //////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
    endtask : wr
    // Read data stand one cycle only, so sample just after the taking edge
    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        @(posedge i_clk_sys);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        #1;
        chk(o_rdata, exp);
    endtask : rd
    // Requests lag their cause by one register stage
    task automatic irqs(input logic c, input logic e);
        repeat (2) @(posedge i_clk_sys);
        #1;
        chk({6'h00, o_core_irq, o_irq}, {6'h00, c, e});
    endtask : irqs
    // One request cycle gives one event cycle; returns on the edge the design takes it
    task automatic pulse(input logic tmr);
        @(posedge i_clk_sys);
        tmr_req <= tmr;
        ext_req <= !tmr;
        @(posedge i_clk_sys);
        tmr_req <= 1'b0;
        ext_req <= 1'b0;
        @(posedge i_clk_sys);
    endtask : pulse
    task automatic flip(input logic [5:0] m);
        @(posedge i_clk_sys);
        flip_req <= m;
        @(posedge i_clk_sys);
        flip_req <= 6'h00;
        @(posedge i_clk_sys);
    endtask : flip
    task automatic set_pend(input logic v);
        @(posedge i_clk_sys);
        pend_req <= v;
    endtask : set_pend
    task automatic do_reset();
        @(posedge i_clk_sys);
        i_rst_n <= 1'b0;
        repeat (5) @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        for (int a = 0; a < 5; a++) rd(a[2:0], 8'h00);
        irqs(1'b0, 1'b0);
    endtask : do_reset
    //////////////////////////////////////////////////////////////////////
    task automatic t_rw();
        wr(3'h0, 8'hff);
        rd(3'h0, 8'hfe);
        wr(3'h0, 8'h00);
        wr(3'h6, 8'hff);
        rd(3'h6, CIC_RD_UNMAPPED);
    endtask : t_rw
    task automatic t_core();
        pulse(1'b1);
        pulse(1'b0);
        rd(3'h0, 8'h06);
        wr(3'h0, 8'h86);
        irqs(1'b0, 1'b0);
        wr(3'h0, 8'ha6);
        irqs(1'b1, 1'b0);
        wr(3'h0, 8'ha0);
        irqs(1'b0, 1'b0);
        pulse(1'b1);
        irqs(1'b1, 1'b0);
        wr(3'h0, 8'h90);
        pulse(1'b0);
        rd(3'h0, 8'h92);
        irqs(1'b1, 1'b0);
        wr(3'h0, 8'h00);
    endtask : t_core
    task automatic t_pin();
        flip(6'h04);
        flip(6'h20);
        rd(CIC_OFS_PER_PIN_FLAGS, 8'h24);
        wr(3'h0, 8'h88);
        irqs(1'b1, 1'b0);
        flip(6'h01);
        irqs(1'b1, 1'b0);
        rd(CIC_OFS_PER_PIN_FLAGS, 8'h25);
        wr(3'h0, 8'h80);
        wr(CIC_OFS_PER_PIN_FLAGS, 8'h20);
        rd(3'h0, 8'h81);
        wr(CIC_OFS_PER_PIN_FLAGS, 8'h00);
        rd(3'h0, 8'h80);
    endtask : t_pin
    task automatic t_periph();
        set_pend(1'b1);
        irqs(1'b0, 1'b0);
        wr(3'h0, 8'hc0);
        irqs(1'b1, 1'b0);
        wr(3'h0, 8'h40);
        irqs(1'b0, 1'b0);
        set_pend(1'b0);
    endtask : t_periph
    task automatic t_evt();
        wr(CIC_OFS_EVT_ENABLE, 8'h07);
        wr(CIC_OFS_EVT_CLEAR, 8'h07);
        irqs(1'b0, 1'b0);
        pulse(1'b1);
        rd(CIC_OFS_EVT_STATUS, 8'h01);
        irqs(1'b0, 1'b1);
        wr(CIC_OFS_EVT_CLEAR, 8'h01);
        irqs(1'b0, 1'b0);
        wr(CIC_OFS_EVT_ENABLE, 8'h00);
        pulse(1'b0);
        rd(CIC_OFS_EVT_STATUS, 8'h02);
        irqs(1'b0, 1'b0);
    endtask : t_evt
    //////////////////////////////////////////////////////////////////////
    initial begin
        i_clk_sys = 1'b0;
        forever #2 i_clk_sys = ~i_clk_sys;
    end
    always @(posedge i_clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            n_errors++;
            end_of_test();
        end
    end
    initial begin
        i_rst_n = 1'b0;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_addr = 3'h0;
        i_wdata = 8'h00;
        tmr_req = 1'b0;
        ext_req = 1'b0;
        pend_req = 1'b0;
        flip_req = 6'h00;
        do_reset();
        t_rw();
        t_core();
        t_pin();
        t_periph();
        t_evt();
        do_reset();
        end_of_test();
    end
endmodule : cic_core_tb_top
